// ==== design/mts_dev_end.sv ====
// transceiver end: run/settle control, frame and block timing, channel status buffers
module mts_dev_end (
    input  wire logic                          clk_sys_in,
    input  wire logic                          resetn_in,
    input  wire logic                          run_in,
    input  wire logic                          clk_master_in,
    input  wire logic                          tcb_master_in,
    input  wire logic                          manual_cs_in,
    input  wire logic                          rx_we_in,
    input  wire logic [mts_pkg::CS_ADDR_W-1:0] rx_addr_in,
    input  wire logic [mts_pkg::CS_WORD_W-1:0] rx_data_in,
    input  wire logic                          host_req_in,
    input  wire logic                          host_we_in,
    input  wire logic [mts_pkg::CS_ADDR_W-1:0] host_addr_in,
    input  wire logic [mts_pkg::CS_WORD_W-1:0] host_wdata_in,
    output logic                               low_power_out,
    output logic                               outputs_on_out,
    output logic                               host_ack_out,
    output logic                               host_refused_out,
    output logic [mts_pkg::CS_WORD_W-1:0]      host_rdata_out,
    output logic                               tx_cs_a_out,
    output logic                               tx_cs_b_out,
    output logic                               tx_block_start_out,
    output logic [7:0]                         frame_idx_out,
    mts_sync_if.dev                            link
);
    mts_pkg::mts_state_t              state_r;
    logic [11:0]                      settle_r;
    logic                             run_on;
    logic [1:0]                       s1_r;
    logic [1:0]                       s2_r;
    logic [1:0]                       s3_r;
    logic [1:0]                       flt_r;
    logic [1:0]                       flt_d_r;
    logic [1:0]                       div_r;
    logic                             bclk_r;
    logic [5:0]                       bit_r;
    logic                             tick;
    logic                             tcb_rise;
    logic [7:0]                       frame_r;
    logic [7:0]                       frame_nxt;
    logic                             blk_nxt;
    logic [mts_pkg::CS_WORD_W-1:0]    e_mem [mts_pkg::CS_WORDS];
    logic [mts_pkg::CS_WORD_W-1:0]    f_mem [mts_pkg::CS_WORDS];
    logic                             host_ok;

    assign run_on = (state_r == mts_pkg::MTS_RUN);

    // run control: reset holds low power, run starts the clock loop settle
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_r  <= mts_pkg::MTS_LOWPWR;
            settle_r <= 12'h000;
        end else begin
            unique case (state_r)
                mts_pkg::MTS_LOWPWR: begin
                    settle_r <= 12'h000;
                    if (run_in) begin
                        state_r <= mts_pkg::MTS_SETTLE;
                    end
                end
                mts_pkg::MTS_SETTLE: begin
                    settle_r <= settle_r + 12'h001;
                    if (!run_in) begin
                        state_r <= mts_pkg::MTS_LOWPWR;
                    end else if (settle_r == mts_pkg::SETTLE_LAST) begin
                        state_r <= mts_pkg::MTS_RUN;
                    end
                end
                mts_pkg::MTS_RUN: begin
                    if (!run_in) begin
                        state_r <= mts_pkg::MTS_LOWPWR;
                    end
                end
                default: begin
                    state_r <= mts_pkg::MTS_LOWPWR;
                end
            endcase
        end
    end

    // boundary and word clock come from another chip: three stages each
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
        end else begin
            s1_r <= {link.tx_block_boundary, link.output_word_clock};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_flt
        // a change counts only once stages two and three agree
        always_ff @(posedge clk_sys_in) begin
            if (!resetn_in) begin
                flt_r[g]   <= 1'b0;
                flt_d_r[g] <= 1'b0;
            end else begin
                if (s2_r[g] == s3_r[g]) begin
                    flt_r[g] <= s3_r[g];
                end
                flt_d_r[g] <= flt_r[g];
            end
        end
    end

    // own bit/word clock divider, used only as clock master
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !run_on || !clk_master_in) begin
            div_r  <= 2'h0;
            bclk_r <= 1'b0;
            bit_r  <= 6'h00;
        end else begin
            div_r <= div_r + 2'h1;
            if (div_r == mts_pkg::BCLK_HALF_LAST) begin
                bclk_r <= ~bclk_r;
                if (bclk_r) begin
                    bit_r <= bit_r + 6'h01;
                end
            end
        end
    end

    // frame starts on the falling word clock edge, own or sensed
    always_comb begin
        if (clk_master_in) begin
            tick = run_on && (div_r == mts_pkg::BCLK_HALF_LAST) && bclk_r
                   && (bit_r == mts_pkg::BITS_FRAME_LAST);
        end else begin
            tick = run_on && flt_d_r[mts_pkg::SYNC_WCLK_POS]
                   && !flt_r[mts_pkg::SYNC_WCLK_POS];
        end
    end

    assign tcb_rise = run_on && !tcb_master_in && flt_r[mts_pkg::SYNC_TCB_POS]
                      && !flt_d_r[mts_pkg::SYNC_TCB_POS];

    // a sensed boundary wins over the local count
    always_comb begin
        frame_nxt = frame_r;
        blk_nxt   = 1'b0;
        if (tcb_rise) begin
            frame_nxt = 8'h00;
            blk_nxt   = 1'b1;
        end else if (tick) begin
            if (frame_r == mts_pkg::FRAMES_LAST) begin
                frame_nxt = 8'h00;
                blk_nxt   = 1'b1;
            end else begin
                frame_nxt = frame_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !run_on) begin
            frame_r <= 8'h00;
        end else begin
            frame_r <= frame_nxt;
        end
    end

    // pins stay sensing until settled; only a configured master drives
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            link.dev_bclk_o  <= 1'b0;
            link.dev_bclk_oe <= 1'b0;
            link.dev_wclk_o  <= 1'b0;
            link.dev_wclk_oe <= 1'b0;
            link.dev_tcb_o   <= 1'b0;
            link.dev_tcb_oe  <= 1'b0;
        end else begin
            link.dev_bclk_o  <= bclk_r;
            link.dev_bclk_oe <= run_on && clk_master_in;
            link.dev_wclk_o  <= bit_r[mts_pkg::WCLK_BIT_POS];
            link.dev_wclk_oe <= run_on && clk_master_in;
            link.dev_tcb_o   <= run_on && (frame_nxt == 8'h00);
            link.dev_tcb_oe  <= run_on && tcb_master_in;
        end
    end

    // buffer access only while run is set
    assign host_ok = host_req_in && run_in;

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            host_ack_out     <= 1'b0;
            host_refused_out <= 1'b0;
            host_rdata_out   <= 16'h0000;
        end else begin
            host_ack_out     <= host_ok;
            host_refused_out <= host_req_in && !run_in;
            if (host_ok) begin
                host_rdata_out <= e_mem[host_addr_in];
            end
        end
    end

    // e buffer: receive side fills it unless the host has taken over; host write wins a clash
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < mts_pkg::CS_WORDS; i++) begin
                e_mem[i] <= 16'h0000;
            end
        end else if (host_ok && host_we_in) begin
            e_mem[host_addr_in] <= host_wdata_in;
        end else if (rx_we_in && !manual_cs_in && run_on) begin
            e_mem[rx_addr_in] <= rx_data_in;
        end
    end

    // f buffer takes a whole block at each boundary, so a block never mixes
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < mts_pkg::CS_WORDS; i++) begin
                f_mem[i] <= 16'h0000;
            end
        end else if (blk_nxt) begin
            f_mem <= e_mem;
        end
    end

    // transmit side, muted until settled; msb of each byte goes first
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !run_on) begin
            tx_cs_a_out        <= 1'b0;
            tx_cs_b_out        <= 1'b0;
            tx_block_start_out <= 1'b0;
            frame_idx_out      <= 8'h00;
        end else begin
            tx_cs_a_out        <= f_mem[frame_r[7:3]][{1'b1, ~frame_r[2:0]}];
            tx_cs_b_out        <= f_mem[frame_r[7:3]][{1'b0, ~frame_r[2:0]}];
            tx_block_start_out <= blk_nxt;
            frame_idx_out      <= frame_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            low_power_out  <= 1'b1;
            outputs_on_out <= 1'b0;
        end else begin
            low_power_out  <= (state_r == mts_pkg::MTS_LOWPWR);
            outputs_on_out <= run_on;
        end
    end
endmodule // mts_dev_end

// ==== design/mts_pkg.sv ====
// shared constants and state type for the multi-transceiver sync ends
package mts_pkg;
    localparam int unsigned CLK_SYS_HZ       = 100_000_000;
    localparam int unsigned SETTLE_TIME_NS   = 20_000;
    localparam int unsigned SETTLE_CYC       = (SETTLE_TIME_NS + 9) / 10;
    localparam logic [11:0] SETTLE_LAST      = 12'(SETTLE_CYC - 1);
    localparam logic [1:0]  BCLK_HALF_LAST   = 2'h3;
    localparam logic [5:0]  BITS_FRAME_LAST  = 6'h3f;
    localparam int unsigned WCLK_BIT_POS     = 5;
    localparam logic [7:0]  FRAMES_LAST      = 8'hbf;
    localparam int unsigned CS_WORDS         = 24;
    localparam int unsigned CS_ADDR_W        = 5;
    localparam int unsigned CS_WORD_W        = 16;
    localparam int unsigned SYNC_TCB_POS     = 1;
    localparam int unsigned SYNC_WCLK_POS    = 0;

    typedef enum logic [1:0] {
        MTS_LOWPWR = 2'b00,
        MTS_SETTLE = 2'b01,
        MTS_RUN    = 2'b11
    } mts_state_t;
endpackage

// ==== design/mts_sync_if.sv ====
// shared bit clock, word clock and block-boundary wires between the two ends
interface mts_sync_if;
    logic dev_bclk_o;
    logic dev_bclk_oe;
    logic dev_wclk_o;
    logic dev_wclk_oe;
    logic dev_tcb_o;
    logic dev_tcb_oe;
    logic oth_bclk_o;
    logic oth_bclk_oe;
    logic oth_wclk_o;
    logic oth_wclk_oe;
    logic oth_tcb_o;
    logic oth_tcb_oe;
    logic output_bit_clock;
    logic output_word_clock;
    logic tx_block_boundary;

    // undriven wires read low, as a pull-down would give
    assign output_bit_clock  = dev_bclk_oe ? dev_bclk_o : (oth_bclk_oe & oth_bclk_o);
    assign output_word_clock = dev_wclk_oe ? dev_wclk_o : (oth_wclk_oe & oth_wclk_o);
    assign tx_block_boundary = dev_tcb_oe  ? dev_tcb_o  : (oth_tcb_oe & oth_tcb_o);

    modport dev (
        output dev_bclk_o, dev_bclk_oe, dev_wclk_o, dev_wclk_oe, dev_tcb_o, dev_tcb_oe,
        input  output_bit_clock, output_word_clock, tx_block_boundary
    );
    modport oth (
        output oth_bclk_o, oth_bclk_oe, oth_wclk_o, oth_wclk_oe, oth_tcb_o, oth_tcb_oe,
        input  output_bit_clock, output_word_clock, tx_block_boundary,
        input  dev_bclk_oe, dev_wclk_oe, dev_tcb_oe
    );
endinterface

// ==== design/mts_ext_sync.sv ====
// far end: external clock and block-boundary source for a group of transceivers
module mts_ext_sync (
    input  wire logic clk_sys_in,
    input  wire logic resetn_in,
    input  wire logic clk_drive_in,
    input  wire logic tcb_drive_in,
    output logic      frame_tick_out,
    output logic      block_start_out,
    output logic      conflict_out,
    mts_sync_if.oth   link
);
    logic [1:0] div_r;
    logic       bclk_r;
    logic [5:0] bit_r;
    logic [7:0] frame_r;
    logic       tick;

    // same divider as a master transceiver, so either may own the clocks
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            div_r  <= 2'h0;
            bclk_r <= 1'b0;
            bit_r  <= 6'h00;
        end else begin
            div_r <= div_r + 2'h1;
            if (div_r == mts_pkg::BCLK_HALF_LAST) begin
                bclk_r <= ~bclk_r;
                if (bclk_r) begin
                    bit_r <= bit_r + 6'h01;
                end
            end
        end
    end

    assign tick = (div_r == mts_pkg::BCLK_HALF_LAST) && bclk_r && (bit_r == mts_pkg::BITS_FRAME_LAST);

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            frame_r <= 8'h00;
        end else if (tick) begin
            frame_r <= (frame_r == mts_pkg::FRAMES_LAST) ? 8'h00 : frame_r + 8'h01;
        end
    end

    // drives only what it is told to own; a clash with a device is reported
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            link.oth_bclk_o  <= 1'b0;
            link.oth_bclk_oe <= 1'b0;
            link.oth_wclk_o  <= 1'b0;
            link.oth_wclk_oe <= 1'b0;
            link.oth_tcb_o   <= 1'b0;
            link.oth_tcb_oe  <= 1'b0;
            frame_tick_out   <= 1'b0;
            block_start_out  <= 1'b0;
            conflict_out     <= 1'b0;
        end else begin
            link.oth_bclk_o  <= bclk_r;
            link.oth_bclk_oe <= clk_drive_in;
            link.oth_wclk_o  <= bit_r[mts_pkg::WCLK_BIT_POS];
            link.oth_wclk_oe <= clk_drive_in;
            // high through all of frame 0, the first frame after reset too
            link.oth_tcb_o   <= (frame_r == 8'h00);
            link.oth_tcb_oe  <= tcb_drive_in;
            frame_tick_out   <= tick;
            block_start_out  <= tick && (frame_r == mts_pkg::FRAMES_LAST);
            conflict_out     <= (clk_drive_in && (link.dev_bclk_oe || link.dev_wclk_oe))
                                || (tcb_drive_in && link.dev_tcb_oe);
        end
    end
endmodule // mts_ext_sync

// ==== sim/mts_sync_assertions.sv ====
// concurrent checks on the wires shared by the transceiver end and the external sync end
module mts_sync_assertions (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic dev_bclk_o,
    input wire logic dev_bclk_oe,
    input wire logic dev_wclk_o,
    input wire logic dev_wclk_oe,
    input wire logic dev_tcb_oe,
    input wire logic oth_bclk_o,
    input wire logic oth_bclk_oe,
    input wire logic oth_wclk_oe,
    input wire logic oth_tcb_oe,
    input wire logic tx_block_boundary
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] wcnt_r;
    logic       wseen_r;
    logic [9:0] hcnt_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // first word clock interval after enable may be short, so it is not judged
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !dev_wclk_oe) begin
            wcnt_r  <= 8'h00;
            wseen_r <= 1'b0;
        end else if ($changed(dev_wclk_o)) begin
            wcnt_r  <= 8'h00;
            wseen_r <= (wcnt_r != 8'h00);
        end else begin
            wcnt_r <= wcnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in || !tx_block_boundary)
            hcnt_r <= 10'h000;
        else
            hcnt_r <= hcnt_r + 10'h001;
    end

    sequence s_dev_half;
        (dev_bclk_oe && $stable(dev_bclk_o))[*3] ##1 (dev_bclk_oe && $changed(dev_bclk_o));
    endsequence

    sequence s_oth_half;
        (oth_bclk_oe && $stable(oth_bclk_o))[*3] ##1 (oth_bclk_oe && $changed(oth_bclk_o));
    endsequence

    a_reset_quiet: assert property (
        $rose(resetn_in) |-> !(dev_bclk_oe || dev_wclk_oe || dev_tcb_oe || oth_bclk_oe || oth_wclk_oe || oth_tcb_oe))
        else $error("a pin is driven right after reset release");
    a_dev_bclk_half: assert property (
        dev_bclk_oe && $past(dev_bclk_oe) && $changed(dev_bclk_o) |=> s_dev_half)
        else $error("device bit clock half period is not 4 cycles");
    // releasing the wire is legal and ends the check; only a driven clock is judged
    a_oth_bclk_half: assert property (disable iff (!resetn_in || !oth_bclk_oe)
        oth_bclk_oe && $past(oth_bclk_oe) && $changed(oth_bclk_o) |=> s_oth_half)
        else $error("external bit clock half period is not 4 cycles");
    a_wclk_period: assert property (
        dev_wclk_oe && wseen_r && $changed(dev_wclk_o) |-> wcnt_r == 8'hff)
        else $error("word clock half period is not 256 cycles");
    a_wclk_on_bclk: assert property (
        dev_wclk_oe && $past(dev_wclk_oe) && $changed(dev_wclk_o)
        |-> $changed(dev_bclk_o) || ($past(dev_bclk_o) != $past(dev_bclk_o, 2)))
        else $error("word clock moved away from a bit clock edge");
    a_clk_oe_pair: assert property (dev_bclk_oe == dev_wclk_oe)
        else $error("bit and word clock enables disagree");
    a_oe_hold: assert property ($rose(dev_bclk_oe) |=> dev_bclk_oe [*8])
        else $error("clock enable dropped soon after rising");
    a_tcb_one_frame: assert property (
        $fell(tx_block_boundary) && !dev_tcb_oe && $past(oth_tcb_oe) |-> hcnt_r == 10'h200)
        else $error("external boundary not high for one frame");
endmodule // mts_sync_assertions

// ==== sim/tb.sv ====
// self-checking bench: transceiver end facing the external sync end
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
`define WAITF(c, n) begin for (wk = 0; wk < (n) && (c) !== 1'b1; wk++) @(negedge clk_sys_in); \
    if ((c) !== 1'b1) begin miscompares++; results(); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        ext_resetn = 1'b1;
    logic        run, clk_master, tcb_master, manual_cs, rx_we, host_req, host_we, clk_drive, tcb_drive;
    logic [4:0]  rx_addr, host_addr;
    logic [15:0] rx_data, host_wdata, host_rdata;
    logic        low_power, outputs_on, host_ack, host_refused, tx_cs_a, tx_cs_b, tx_block_start, conflict;
    logic        ext_tick;
    logic [7:0]  frame_idx;
    logic        ack_seen, ref_seen;
    int          miscompares = 0;
    int          checked = 0;
    int          wk;

    always #5 clk_sys_in = ~clk_sys_in;

    mts_sync_if lnk ();
    mts_dev_end i_mts_dev_end (.clk_sys_in, .resetn_in, .run_in(run), .clk_master_in(clk_master),
        .tcb_master_in(tcb_master), .manual_cs_in(manual_cs), .rx_we_in(rx_we), .rx_addr_in(rx_addr),
        .rx_data_in(rx_data), .host_req_in(host_req), .host_we_in(host_we), .host_addr_in(host_addr),
        .host_wdata_in(host_wdata), .low_power_out(low_power), .outputs_on_out(outputs_on),
        .host_ack_out(host_ack), .host_refused_out(host_refused), .host_rdata_out(host_rdata),
        .tx_cs_a_out(tx_cs_a), .tx_cs_b_out(tx_cs_b), .tx_block_start_out(tx_block_start),
        .frame_idx_out(frame_idx), .link(lnk));
    // separate far-end reset lets a fresh boundary arrive while the device runs
    mts_ext_sync i_mts_ext_sync (.clk_sys_in, .resetn_in(resetn_in && ext_resetn), .clk_drive_in(clk_drive),
        .tcb_drive_in(tcb_drive), .frame_tick_out(ext_tick), .block_start_out(),
        .conflict_out(conflict), .link(lnk));
    mts_sync_assertions i_chk (.clk_sys_in, .resetn_in, .dev_bclk_o(lnk.dev_bclk_o),
        .dev_bclk_oe(lnk.dev_bclk_oe), .dev_wclk_o(lnk.dev_wclk_o), .dev_wclk_oe(lnk.dev_wclk_oe),
        .dev_tcb_oe(lnk.dev_tcb_oe), .oth_bclk_o(lnk.oth_bclk_o), .oth_bclk_oe(lnk.oth_bclk_oe),
        .oth_wclk_oe(lnk.oth_wclk_oe), .oth_tcb_oe(lnk.oth_tcb_oe), .tx_block_boundary(lnk.tx_block_boundary));

    task automatic xfer(input logic we, input logic [4:0] a, input logic [15:0] d, input logic good);
        host_req = 1'b1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        @(negedge clk_sys_in);
        host_req = 1'b0;
        ack_seen = host_ack;
        ref_seen = host_refused;
        @(negedge clk_sys_in);
        ack_seen |= host_ack;
        ref_seen |= host_refused;
        `CHK("host_ack", good, ack_seen)
        `CHK("host_refused", !good, ref_seen)
    endtask

    task automatic rx_write(input logic [4:0] a, input logic [15:0] d);
        rx_we = 1'b1;
        rx_addr = a;
        rx_data = d;
        @(negedge clk_sys_in);
        rx_we = 1'b0;
        @(negedge clk_sys_in);
    endtask

    task automatic t_reset;
        `CHK("low_power", 1'b1, low_power)
        `CHK("outputs_on", 1'b0, outputs_on)
        `CHK("tx_cs_a", 1'b0, tx_cs_a)
        `CHK("tcb_oe", 1'b0, lnk.dev_tcb_oe)
    endtask

    task automatic t_run;
        run = 1'b1;
        `WAITF(low_power === 1'b0, 4)
        `WAITF(outputs_on === 1'b1, 2100)
        `CHK("settle_time", 1'b1, wk >= 1995 && wk <= 2005)
    endtask

    task automatic t_buffer;
        xfer(1'b0, 5'h03, 16'h0000, 1'b1);
        `CHK("refused_write", 16'h0000, host_rdata)
        xfer(1'b1, 5'h17, 16'hbeef, 1'b1);
        xfer(1'b0, 5'h17, 16'h0000, 1'b1);
        `CHK("rdata_23", 16'hbeef, host_rdata)
        manual_cs = 1'b1;
        rx_write(5'h07, 16'haaaa);
        xfer(1'b0, 5'h07, 16'h0000, 1'b1);
        `CHK("rx_ignored", 16'h0000, host_rdata)
        manual_cs = 1'b0;
        rx_write(5'h07, 16'h5a5a);
        xfer(1'b0, 5'h07, 16'h0000, 1'b1);
        `CHK("rx_auto", 16'h5a5a, host_rdata)
        xfer(1'b1, 5'h00, 16'h8000, 1'b1);
    endtask

    task automatic t_slave;
        tcb_drive = 1'b1;
        clk_drive = 1'b1;
        ext_resetn = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        ext_resetn = 1'b1;
        `WAITF(tx_block_start === 1'b1, 40)
        `CHK("frame_idx", 8'h00, frame_idx)
        repeat (4) @(negedge clk_sys_in);
        `CHK("cs_a_frame0", 1'b1, tx_cs_a)
        `CHK("cs_b_frame0", 1'b0, tx_cs_b)
        `WAITF(ext_tick === 1'b1, 600)
        @(negedge clk_sys_in);
        `CHK("tcb_end", 1'b0, lnk.tx_block_boundary)
        repeat (8) @(negedge clk_sys_in);
        `CHK("frame_idx_s", 8'h01, frame_idx)
    endtask

    task automatic t_stop;
        run = 1'b0;
        `WAITF(low_power === 1'b1, 3)
        `CHK("muted", 1'b0, outputs_on)
        `CHK("cs_muted", 1'b0, tx_cs_a)
        xfer(1'b0, 5'h00, 16'h0000, 1'b0);
    endtask

    task automatic t_master;
        tcb_drive = 1'b0;
        clk_master = 1'b1;
        tcb_master = 1'b1;
        clk_drive = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        `CHK("no_conflict", 1'b0, conflict)
        t_run();
        `CHK("tcb_driven", 1'b1, lnk.dev_tcb_oe)
        `CHK("bclk_driven", 1'b1, lnk.dev_bclk_oe)
        `CHK("tcb_frame0", 1'b1, lnk.tx_block_boundary)
        @(negedge clk_sys_in);
        `CHK("conflict", 1'b1, conflict)
        repeat (1200) @(negedge clk_sys_in);
        `CHK("frame_idx_m", 8'h02, frame_idx)
        clk_drive = 1'b0;
        `WAITF(conflict === 1'b0, 20)
    endtask

    task automatic results;
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        {run, clk_master, tcb_master, manual_cs, rx_we, host_req, host_we, clk_drive, tcb_drive} = '0;
        {rx_addr, host_addr, rx_data, host_wdata} = '0;
        repeat (5) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        @(negedge clk_sys_in);
        t_reset();
        xfer(1'b1, 5'h03, 16'h1234, 1'b0);
        t_run();
        t_buffer();
        t_slave();
        t_stop();
        t_master();
        results();
    end

    initial begin
        repeat (40000) @(posedge clk_sys_in);
        miscompares++;
        results();
    end
endmodule // tb
